//--- include/vtsp_pkg.sv
// Purpose: Shared constants and types of the serial transfer port controller
// Assumes: 50 MHz controller clock, 32-bit software register port
// Notes:   Timing counts derive from nanosecond figures at the clock rate
package vtsp_pkg;

    localparam int CLK_MHZ = 50;
    localparam int ROW_W   = 9;
    localparam int COL_W   = 8;
    localparam int DATA_W  = 8;

    // Software register map, byte addresses
    localparam logic [7:0] REG_CMD    = 8'h00;
    localparam logic [7:0] REG_ROW    = 8'h04;
    localparam logic [7:0] REG_TAP    = 8'h08;
    localparam logic [7:0] REG_SDATA  = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;

    // Command codes written to REG_CMD
    localparam logic [2:0] OP_READ   = 3'h1;
    localparam logic [2:0] OP_SPLIT  = 3'h2;
    localparam logic [2:0] OP_WRITE  = 3'h3;
    localparam logic [2:0] OP_ALTWR  = 3'h4;
    localparam logic [2:0] OP_PSEUDO = 3'h5;
    localparam logic [2:0] OP_SHIFT  = 3'h6;

    // Status field positions
    localparam int ST_BUSY_B   = 0;
    localparam int ST_WMODE_B  = 1;
    localparam int ST_MVALID_B = 2;
    localparam int ST_SPEND_B  = 3;
    localparam int ST_ESEQ_B   = 4;
    localparam int ST_EMODE_B  = 5;
    localparam int ST_FULL_B   = 6;
    localparam int ST_PTR_LSB  = 8;

    // Half boundaries of the data register and the minimum shift gap before a split
    localparam logic [COL_W-1:0] LOW_END  = 8'h7F;
    localparam logic [COL_W-1:0] HIGH_END = 8'hFF;
    localparam logic [1:0]       MIN_SHIFT_GAP = 2'h2;

    // Phase lengths in ns
    localparam int T_SETUP_NS  = 20;
    localparam int T_RASCAS_NS = 40;
    localparam int T_CAS_NS    = 40;
    localparam int T_TRGRAS_NS = 20;
    localparam int T_PRE_NS    = 80;
    localparam int T_SCHI_NS   = 25;
    localparam int T_SCLO_NS   = 25;

    function automatic int cyc(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int C_SETUP  = cyc(T_SETUP_NS);
    localparam int C_RASCAS = cyc(T_RASCAS_NS);
    localparam int C_CAS    = cyc(T_CAS_NS);
    localparam int C_TRGRAS = cyc(T_TRGRAS_NS);
    localparam int C_PRE    = cyc(T_PRE_NS);
    localparam int C_SCHI   = cyc(T_SCHI_NS);
    localparam int C_SCLO   = cyc(T_SCLO_NS);

    typedef enum logic [2:0] {
        ST_IDLE, ST_SETUP, ST_RAS, ST_CAS, ST_TRG, ST_PRE, ST_SCHI, ST_SCLO
    } vtsp_state_t;

    typedef struct packed {
        logic              ras_n;
        logic              cas_n;
        logic              xctl_n;
        logic              w_n;
        logic              sfsel;
        logic              spen_n;
        logic              shclk;
        logic [ROW_W-1:0]  addr;
        logic [DATA_W-1:0] sdat_out;
        logic              sdat_oe_n;
    } vtsp_pins_t;

endpackage

//--- logic/vtsp_ctrl.sv
// Purpose: Controller driving transfer cycles and the serial port of a video DRAM
// Assumes: Software port with one-cycle strobes, read data one cycle later
// Notes:   One command at a time; commands written while busy are dropped
// Operation
// R1: Row strobe falls, transfer control, write and serial enable low: register-to-memory
// R2: Row strobe falls, transfer control and write low, special function high: alternate write
// R3: Enter write mode via pseudo-transfer or transfer write before shifting data in
// R4: Row strobe falls, transfer control low, write high, special function low: full read
// R5: Row strobe falls, transfer control low, write high, special function high: split
// R6: A read transfer loads all 256 register locations from one row
// R7: Random data outputs stay high impedance during read transfers
// R8: Register contents can be shifted out or written back to another row
// R9: After a read transfer, first bit follows shift clock rise after transfer control high
// R10: At least two shift clocks between split reloads and after a read transfer
// R11: Do a full read transfer before the first split transfer
// R12: Split transfer to inactive half may precede boundary 127 or 255
// R13: At a half boundary the counter reloads with the split tap
// R14: Only a read transfer returns the serial port to read mode; here a split transfer also clears write mode
// R15: Serial input is written starting at the tap of the last transfer
// R16: Hold transfer control high at each row strobe fall during serial access
// R17: A transfer write after a read transfer puts the port in write mode
// R18: Serial enable held high as row strobe falls for write-mode control
// R19: Write-mode control turns serial pins from output to input
// R20: Each shift clock rise advances the serial counter by one location
module vtsp_ctrl #(
    parameter int ROW_W  = vtsp_pkg::ROW_W,
    parameter int COL_W  = vtsp_pkg::COL_W,
    parameter int DATA_W = vtsp_pkg::DATA_W
) (
    input  wire logic              MCLK_I,
    input  wire logic              RST_I,
    input  wire logic [7:0]        ADDR_I,
    input  wire logic [31:0]       WDATA_I,
    input  wire logic              WR_I,
    input  wire logic              RD_I,
    output logic      [31:0]       RDATA_O,
    output logic                   RAS_N_O,
    output logic                   CAS_N_O,
    output logic                   TRANSFER_CONTROL_N_O,
    output logic                   W_N_O,
    output logic                   SPECIAL_FUNCTION_SELECT_O,
    output logic                   SERIAL_PORT_ENABLE_N_O,
    output logic                   SERIAL_SHIFT_CLOCK_O,
    output logic      [ROW_W-1:0]  MEM_ADDR_O,
    input  wire logic [DATA_W-1:0] SERIAL_DATA_PINS_I,
    output logic      [DATA_W-1:0] SERIAL_DATA_PINS_O,
    output logic                   SERIAL_DATA_PINS_OE_N_O
);

    typedef struct packed {
        vtsp_pkg::vtsp_state_t st;
        logic [3:0]            tmr;
        logic [2:0]            op;
        logic [ROW_W-1:0]      row;
        logic [COL_W-1:0]      tap;
        logic [DATA_W-1:0]     wdata;
        logic [DATA_W-1:0]     sdata;
        logic [31:0]           rdata;
        vtsp_pkg::vtsp_pins_t  pins;
        logic                  wmode;
        logic                  mvalid;
        logic                  full_done;
        logic [1:0]            shift_since;
        logic [COL_W-1:0]      ptr;
        logic [COL_W-1:0]      split_tap;
        logic                  split_pend;
        logic                  err_seq;
        logic                  err_mode;
        logic [DATA_W-1:0]     pin_s1;
        logic [DATA_W-1:0]     pin_s2;
    } vtsp_ctrl_state_t;

    vtsp_ctrl_state_t s_reg;
    vtsp_ctrl_state_t s_next;
    logic             shift_done;
    logic             at_bound;

    function automatic logic [3:0] ld(input int c);
        return 4'(c - 1);
    endfunction

    function automatic logic is_wr_op(input logic [2:0] op);
        return (op == vtsp_pkg::OP_WRITE) || (op == vtsp_pkg::OP_ALTWR)
            || (op == vtsp_pkg::OP_PSEUDO);
    endfunction

    assign at_bound   = (s_reg.ptr == vtsp_pkg::LOW_END) || (s_reg.ptr == vtsp_pkg::HIGH_END);
    assign shift_done = (s_reg.st == vtsp_pkg::ST_SCLO) && (s_reg.tmr == 4'h0);

    always_comb
    begin
        logic wr_cmd;
        logic [2:0] op_in;
        wr_cmd = WR_I && (ADDR_I == vtsp_pkg::REG_CMD);
        op_in  = WDATA_I[2:0];
        s_next = s_reg;
        s_next.pin_s1 = SERIAL_DATA_PINS_I;
        s_next.pin_s2 = s_reg.pin_s1;
        if (s_reg.tmr != 4'h0)
        begin
            s_next.tmr = s_reg.tmr - 4'h1;
        end

        // Software port
        if (WR_I && ADDR_I == vtsp_pkg::REG_ROW)
        begin
            s_next.row = WDATA_I[ROW_W-1:0];
        end
        if (WR_I && ADDR_I == vtsp_pkg::REG_TAP)
        begin
            s_next.tap = WDATA_I[COL_W-1:0];
        end
        if (WR_I && ADDR_I == vtsp_pkg::REG_SDATA)
        begin
            s_next.wdata = WDATA_I[DATA_W-1:0];
        end
        if (WR_I && ADDR_I == vtsp_pkg::REG_STATUS)
        begin
            if (WDATA_I[vtsp_pkg::ST_ESEQ_B])
            begin
                s_next.err_seq = 1'b0;
            end
            if (WDATA_I[vtsp_pkg::ST_EMODE_B])
            begin
                s_next.err_mode = 1'b0;
            end
        end
        s_next.rdata = 32'h0;
        if (RD_I)
        begin
            unique case (ADDR_I)
                vtsp_pkg::REG_ROW:   s_next.rdata = 32'(s_reg.row);
                vtsp_pkg::REG_TAP:   s_next.rdata = 32'(s_reg.tap);
                vtsp_pkg::REG_SDATA: s_next.rdata = 32'(s_reg.sdata);
                vtsp_pkg::REG_STATUS:
                begin
                    s_next.rdata[vtsp_pkg::ST_BUSY_B]   = s_reg.st != vtsp_pkg::ST_IDLE;
                    s_next.rdata[vtsp_pkg::ST_WMODE_B]  = s_reg.wmode;
                    s_next.rdata[vtsp_pkg::ST_MVALID_B] = s_reg.mvalid;
                    s_next.rdata[vtsp_pkg::ST_SPEND_B]  = s_reg.split_pend;
                    s_next.rdata[vtsp_pkg::ST_ESEQ_B]   = s_reg.err_seq;
                    s_next.rdata[vtsp_pkg::ST_EMODE_B]  = s_reg.err_mode;
                    s_next.rdata[vtsp_pkg::ST_FULL_B]   = s_reg.full_done;
                    s_next.rdata[vtsp_pkg::ST_PTR_LSB +: COL_W] = s_reg.ptr;
                end
                default: s_next.rdata = 32'h0;
            endcase
        end

        unique case (s_reg.st)
            vtsp_pkg::ST_IDLE:
            begin
                if (wr_cmd && op_in == vtsp_pkg::OP_SHIFT)
                begin
                    if (!s_reg.mvalid)
                    begin
                        s_next.err_mode = 1'b1;
                    end
                    else
                    begin
                        // Serial access: transfer control high, data set before clock rise
                        s_next.op            = op_in;
                        s_next.pins.xctl_n   = 1'b1; // R16
                        s_next.pins.spen_n   = 1'b0;
                        s_next.pins.sdat_out = s_reg.wdata; // R15
                        s_next.st            = vtsp_pkg::ST_SETUP;
                        s_next.tmr           = ld(vtsp_pkg::C_SETUP);
                    end
                end
                else if (wr_cmd && op_in == vtsp_pkg::OP_SPLIT
                         && (!s_reg.full_done || s_reg.shift_since < vtsp_pkg::MIN_SHIFT_GAP))
                begin
                    s_next.err_seq = 1'b1; // R10 R11
                end
                else if (wr_cmd && op_in >= vtsp_pkg::OP_READ && op_in <= vtsp_pkg::OP_PSEUDO)
                begin
                    s_next.op          = op_in;
                    s_next.pins.addr   = s_reg.row;
                    s_next.pins.xctl_n = 1'b0;
                    s_next.pins.w_n    = !is_wr_op(op_in); // R1 R2 R3 R4 R5
                    s_next.pins.sfsel  = (op_in == vtsp_pkg::OP_SPLIT)
                                      || (op_in == vtsp_pkg::OP_ALTWR); // R2 R5
                    s_next.pins.spen_n = (op_in != vtsp_pkg::OP_WRITE); // R1 R18
                    s_next.pins.shclk  = 1'b0;
                    if (!is_wr_op(op_in))
                    begin
                        s_next.pins.sdat_oe_n = 1'b1; // R14
                    end
                    s_next.st  = vtsp_pkg::ST_SETUP;
                    s_next.tmr = ld(vtsp_pkg::C_SETUP);
                end
            end
            vtsp_pkg::ST_SETUP:
            begin
                if (s_reg.tmr == 4'h0)
                begin
                    if (s_reg.op == vtsp_pkg::OP_SHIFT)
                    begin
                        s_next.pins.shclk = 1'b1; // R20
                        s_next.st      = vtsp_pkg::ST_SCHI;
                        s_next.tmr     = ld(vtsp_pkg::C_SCHI);
                    end
                    else
                    begin
                        s_next.pins.ras_n = 1'b0;
                        s_next.st         = vtsp_pkg::ST_RAS;
                        s_next.tmr        = ld(vtsp_pkg::C_RASCAS);
                    end
                end
            end
            vtsp_pkg::ST_RAS:
            begin
                if (s_reg.tmr == 4'h0)
                begin
                    s_next.pins.addr  = ROW_W'(s_reg.tap);
                    s_next.pins.cas_n = 1'b0;
                    s_next.st         = vtsp_pkg::ST_CAS;
                    s_next.tmr        = ld(vtsp_pkg::C_CAS);
                end
            end
            vtsp_pkg::ST_CAS:
            begin
                if (s_reg.tmr == 4'h0)
                begin
                    s_next.pins.xctl_n = 1'b1; // R9
                    s_next.st         = vtsp_pkg::ST_TRG;
                    s_next.tmr        = ld(vtsp_pkg::C_TRGRAS);
                end
            end
            vtsp_pkg::ST_TRG:
            begin
                if (s_reg.tmr == 4'h0)
                begin
                    s_next.pins.ras_n = 1'b1;
                    s_next.pins.cas_n = 1'b1;
                    s_next.pins.w_n   = 1'b1;
                    s_next.pins.sfsel  = 1'b0;
                    s_next.pins.spen_n = 1'b1;
                    s_next.st         = vtsp_pkg::ST_PRE;
                    s_next.tmr        = ld(vtsp_pkg::C_PRE);
                end
            end
            vtsp_pkg::ST_PRE:
            begin
                if (s_reg.tmr == 4'h0)
                begin
                    s_next.st          = vtsp_pkg::ST_IDLE;
                    s_next.mvalid      = 1'b1;
                    s_next.shift_since = 2'h0;
                    if (s_reg.op == vtsp_pkg::OP_SPLIT)
                    begin
                        s_next.split_tap  = s_reg.tap; // R12
                        s_next.split_pend = 1'b1;
                        s_next.wmode      = 1'b0;
                    end
                    else
                    begin
                        s_next.ptr        = s_reg.tap; // R6 R15
                        s_next.split_pend = 1'b0;
                        s_next.wmode      = is_wr_op(s_reg.op); // R14 R17
                        s_next.pins.sdat_oe_n = !is_wr_op(s_reg.op); // R19
                        if (s_reg.op == vtsp_pkg::OP_READ)
                        begin
                            s_next.full_done = 1'b1; // R11
                        end
                    end
                end
            end
            vtsp_pkg::ST_SCHI:
            begin
                if (s_reg.tmr == 4'h0)
                begin
                    s_next.pins.shclk = 1'b0;
                    s_next.st      = vtsp_pkg::ST_SCLO;
                    s_next.tmr     = ld(vtsp_pkg::C_SCLO);
                end
            end
            vtsp_pkg::ST_SCLO:
            begin
                if (s_reg.tmr == 4'h0)
                begin
                    s_next.st        = vtsp_pkg::ST_IDLE;
                    s_next.pins.spen_n = 1'b1;
                    if (!s_reg.wmode)
                    begin
                        s_next.sdata = s_reg.pin_s2; // R9
                    end
                    if (s_reg.shift_since != 2'h3)
                    begin
                        s_next.shift_since = s_reg.shift_since + 2'h1; // R10
                    end
                    if (at_bound && s_reg.split_pend)
                    begin
                        s_next.ptr        = s_reg.split_tap; // R13
                        s_next.split_pend = 1'b0;
                    end
                    else
                    begin
                        s_next.ptr = s_reg.ptr + 8'h01; // R20
                    end
                end
            end
        endcase
    end

    always_ff @(posedge MCLK_I)
    begin
        if (RST_I)
        begin
            s_reg              <= '0;
            s_reg.st           <= vtsp_pkg::ST_IDLE;
            s_reg.pins.ras_n   <= 1'b1;
            s_reg.pins.cas_n   <= 1'b1;
            s_reg.pins.xctl_n    <= 1'b1;
            s_reg.pins.w_n       <= 1'b1;
            s_reg.pins.spen_n    <= 1'b1;
            s_reg.pins.sdat_oe_n <= 1'b1;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign RDATA_O                   = s_reg.rdata;
    assign RAS_N_O                   = s_reg.pins.ras_n;
    assign CAS_N_O                   = s_reg.pins.cas_n;
    assign TRANSFER_CONTROL_N_O      = s_reg.pins.xctl_n;
    assign W_N_O                     = s_reg.pins.w_n;
    assign SPECIAL_FUNCTION_SELECT_O = s_reg.pins.sfsel;
    assign SERIAL_PORT_ENABLE_N_O    = s_reg.pins.spen_n;
    assign SERIAL_SHIFT_CLOCK_O      = s_reg.pins.shclk;
    assign MEM_ADDR_O                = s_reg.pins.addr;
    assign SERIAL_DATA_PINS_O        = s_reg.pins.sdat_out;
    assign SERIAL_DATA_PINS_OE_N_O   = s_reg.pins.sdat_oe_n;

    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (RST_I);

    AST_R1_XFER_WRITE: assert property ($fell(RAS_N_O) && s_reg.op == vtsp_pkg::OP_WRITE // R1
        |-> !TRANSFER_CONTROL_N_O && !W_N_O && !SERIAL_PORT_ENABLE_N_O)
        else $error("transfer write decode wrong");
    AST_R2_ALT_WRITE: assert property ($fell(RAS_N_O) && s_reg.op == vtsp_pkg::OP_ALTWR // R2
        |-> !TRANSFER_CONTROL_N_O && !W_N_O && SPECIAL_FUNCTION_SELECT_O)
        else $error("alternate write decode wrong");
    AST_R3_DRIVE_WMODE: assert property (!SERIAL_DATA_PINS_OE_N_O |-> s_reg.wmode) // R3
        else $error("serial pins driven outside write mode");
    AST_R18_PSEUDO: assert property ($fell(RAS_N_O) && s_reg.op == vtsp_pkg::OP_PSEUDO // R18
        |-> !TRANSFER_CONTROL_N_O && !W_N_O && !SPECIAL_FUNCTION_SELECT_O
            && SERIAL_PORT_ENABLE_N_O)
        else $error("pseudo-transfer decode wrong");
    AST_R4_READ: assert property ($fell(RAS_N_O) && s_reg.op == vtsp_pkg::OP_READ // R4
        |-> !TRANSFER_CONTROL_N_O && W_N_O && !SPECIAL_FUNCTION_SELECT_O
            && SERIAL_DATA_PINS_OE_N_O)
        else $error("read transfer decode wrong");
    AST_R5_SPLIT: assert property ($fell(RAS_N_O) && s_reg.op == vtsp_pkg::OP_SPLIT // R5
        |-> !TRANSFER_CONTROL_N_O && W_N_O && SPECIAL_FUNCTION_SELECT_O)
        else $error("split transfer decode wrong");
    AST_R9_XCTL_FIRST: assert property ($fell(RAS_N_O) // R9
        |-> !SERIAL_SHIFT_CLOCK_O throughout (##[1:12] $rose(TRANSFER_CONTROL_N_O)))
        else $error("shift clock rose before transfer control returned high");
    AST_R10_SHIFT_GAP: assert property ($fell(RAS_N_O) && s_reg.op == vtsp_pkg::OP_SPLIT // R10
        |-> s_reg.shift_since >= vtsp_pkg::MIN_SHIFT_GAP && s_reg.full_done) // R11
        else $error("split transfer issued too early");
    AST_R16_XCTL_HIGH: assert property (SERIAL_SHIFT_CLOCK_O |-> TRANSFER_CONTROL_N_O) // R16
        else $error("transfer control low during serial access");
    AST_R13_RELOAD: assert property (shift_done && at_bound && s_reg.split_pend // R13
        |=> s_reg.ptr == $past(s_reg.split_tap) && !s_reg.split_pend)
        else $error("counter not reloaded at boundary");
    AST_R20_ADVANCE: assert property (shift_done && !(at_bound && s_reg.split_pend) // R20
        |=> s_reg.ptr == 8'($past(s_reg.ptr) + 1))
        else $error("counter did not advance");

    COV_READ:   cover property ($fell(RAS_N_O) && s_reg.op == vtsp_pkg::OP_READ);
    COV_SPLIT:  cover property ($fell(RAS_N_O) && s_reg.op == vtsp_pkg::OP_SPLIT);
    COV_PSEUDO: cover property ($fell(RAS_N_O) && s_reg.op == vtsp_pkg::OP_PSEUDO);
    COV_SHIFTW: cover property (shift_done && s_reg.wmode);
    COV_RELOAD: cover property (shift_done && at_bound && s_reg.split_pend);

endmodule

//--- verification/vtsp_dev_model.sv
// Purpose: Behavioural video DRAM transfer and serial port
// Assumes: Strobes and shift clock come from the controller
// Notes:   Register data is row xor column; released pins show inverted data unless serial read is enabled
module vtsp_dev_model (
    input  wire logic       ras_n_i,
    input  wire logic       cas_n_i,
    input  wire logic       xctl_n_i,
    input  wire logic       w_n_i,
    input  wire logic       sfsel_i,
    input  wire logic       spen_n_i,
    input  wire logic       shclk_i,
    input  wire logic [8:0] addr_i,
    input  wire logic [7:0] sdat_i,
    input  wire logic       oe_n_i,
    output logic      [7:0] pin_o,
    output logic      [2:0] fn_o,
    output logic      [7:0] wcol_o,
    output logic      [7:0] wdat_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt = 8'h00;
    logic [7:0] stap = 8'h00;
    logic [7:0] shout = 8'h00;
    logic [7:0] row = 8'h00;
    logic [7:0] rlo = 8'h00;
    logic [7:0] rhi = 8'h00;
    logic       wmode = 1'b0;
    logic       pend = 1'b0;
    initial fn_o = 3'h0;
    initial wcol_o = 8'h00;
    initial wdat_o = 8'h00;
    // Released pins show the inverse, except during serial read access, rather than a stale value
    assign pin_o = !oe_n_i ? sdat_i : ((!wmode && !spen_n_i) ? shout : ~shout);
    always @(negedge ras_n_i)
    begin
        row = addr_i[7:0];
        fn_o = 3'h0;
        if (!xctl_n_i && !w_n_i && sfsel_i)
            fn_o = vtsp_pkg::OP_ALTWR;
        else if (!xctl_n_i && !w_n_i)
            fn_o = spen_n_i ? vtsp_pkg::OP_PSEUDO : vtsp_pkg::OP_WRITE;
        else if (!xctl_n_i)
            fn_o = sfsel_i ? vtsp_pkg::OP_SPLIT : vtsp_pkg::OP_READ;
    end
    always @(negedge cas_n_i)
    begin
        if (fn_o == vtsp_pkg::OP_READ)
        begin
            rlo = row;
            rhi = row;
            cnt = addr_i[7:0];
            wmode = 1'b0;
            pend = 1'b0;
        end
        else if (fn_o == vtsp_pkg::OP_SPLIT)
        begin
            if (cnt[7]) rlo = row;
            else rhi = row;
            stap = addr_i[7:0];
            pend = 1'b1;
        end
        else if (fn_o != 3'h0)
        begin
            cnt = addr_i[7:0];
            wmode = 1'b1;
        end
    end
    always @(posedge shclk_i)
    begin
        if (!spen_n_i)
        begin
            if (wmode)
            begin
                wcol_o = cnt;
                wdat_o = pin_o;
            end
            else shout = (cnt[7] ? rhi : rlo) ^ cnt;
            if (pend && (cnt == 8'h7F || cnt == 8'hFF))
            begin
                cnt = stap;
                pend = 1'b0;
            end
            else cnt = cnt + 8'h01;
        end
    end
endmodule

//--- verification/tb_vtsp_ctrl.sv
// Purpose: Self-checking bench of the serial transfer port controller
// Assumes: Device model on the far side, software port driven here
// Notes:   Expected register data is row xor column
module tb_vtsp_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, s;
    logic ras_n, cas_n, xctl_n, w_n, sfsel, spen_n, shclk, oe_n;
    logic [8:0] maddr;
    logic [7:0] sdi, sdo, wcol, wdat;
    logic [2:0] fn;
    int n_mismatch = 0;
    int compares = 0;
    always #10 clk = ~clk;
    vtsp_ctrl vtsp_ctrl_i (.MCLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .RAS_N_O(ras_n), .CAS_N_O(cas_n),
        .TRANSFER_CONTROL_N_O(xctl_n), .W_N_O(w_n), .SPECIAL_FUNCTION_SELECT_O(sfsel),
        .SERIAL_PORT_ENABLE_N_O(spen_n), .SERIAL_SHIFT_CLOCK_O(shclk), .MEM_ADDR_O(maddr),
        .SERIAL_DATA_PINS_I(sdi), .SERIAL_DATA_PINS_O(sdo), .SERIAL_DATA_PINS_OE_N_O(oe_n));
    vtsp_dev_model vtsp_dev_model_i (.ras_n_i(ras_n), .cas_n_i(cas_n), .xctl_n_i(xctl_n),
        .w_n_i(w_n), .sfsel_i(sfsel), .spen_n_i(spen_n), .shclk_i(shclk), .addr_i(maddr),
        .sdat_i(sdo),
        .oe_n_i(oe_n), .pin_o(sdi), .fn_o(fn), .wcol_o(wcol), .wdat_o(wdat));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    task automatic cmd(input logic [2:0] op);
        int k;
        k = 0;
        wreg(vtsp_pkg::REG_CMD, {29'h0, op});
        rreg(vtsp_pkg::REG_STATUS, s);
        while (s[0] !== 1'b0 && k < 100)
        begin
            rreg(vtsp_pkg::REG_STATUS, s);
            k++;
        end
        chk("idle", s[0], 1'b0);
    endtask
    task automatic shift(input logic [7:0] exp, input logic [7:0] ptr);
        cmd(vtsp_pkg::OP_SHIFT);
        chk("ptr", s[15:8], ptr);
        rreg(vtsp_pkg::REG_SDATA, s);
        chk("sdata", s[7:0], exp);
    endtask
    task automatic t_reset();
        rreg(vtsp_pkg::REG_STATUS, s);
        chk("status", s, 32'h0);
        rreg(8'h20, s);
        chk("unmapped", s, 32'h0);
        cmd(vtsp_pkg::OP_SHIFT);
        chk("err_mode", s[5], 1'b1);
        cmd(vtsp_pkg::OP_SPLIT);
        chk("err_seq", s[4], 1'b1);
        wreg(vtsp_pkg::REG_STATUS, 32'h30);
        rreg(vtsp_pkg::REG_STATUS, s);
        chk("cleared", s[5:4], 2'h0);
        $display("test reset done");
    endtask
    task automatic t_read();
        wreg(vtsp_pkg::REG_ROW, 32'h123);
        wreg(vtsp_pkg::REG_TAP, 32'h7D);
        cmd(vtsp_pkg::OP_READ);
        chk("fn", fn, vtsp_pkg::OP_READ);
        chk("modes", s[6:1], 6'h22);
        shift(8'h23 ^ 8'h7D, 8'h7E);
        cmd(vtsp_pkg::OP_SPLIT);
        chk("gap", s[4], 1'b1);
        wreg(vtsp_pkg::REG_STATUS, 32'h10);
        shift(8'h23 ^ 8'h7E, 8'h7F);
        wreg(vtsp_pkg::REG_ROW, 32'h0AA);
        wreg(vtsp_pkg::REG_TAP, 32'h90);
        cmd(vtsp_pkg::OP_SPLIT);
        chk("fn", fn, vtsp_pkg::OP_SPLIT);
        chk("pend", s[4:3], 2'h1);
        shift(8'h23 ^ 8'h7F, 8'h90);
        shift(8'hAA ^ 8'h90, 8'h91);
        $display("test read and split done");
    endtask
    task automatic t_write();
        logic [2:0] ops [3];
        ops = '{vtsp_pkg::OP_WRITE, vtsp_pkg::OP_ALTWR, vtsp_pkg::OP_PSEUDO};
        for (int i = 0; i < 3; i++)
        begin
            wreg(vtsp_pkg::REG_TAP, 32'h40 + i);
            cmd(ops[i]);
            chk("fn", fn, ops[i]);
            chk("wmode", {s[2:1], oe_n}, 3'h6);
            wreg(vtsp_pkg::REG_SDATA, 32'h5A + i);
            cmd(vtsp_pkg::OP_SHIFT);
            chk("wcol", wcol, 8'h40 + i);
            chk("wdat", wdat, 8'h5A + i);
        end
        cmd(vtsp_pkg::OP_READ);
        chk("rmode", {s[1], oe_n}, 2'h1);
        $display("test write modes done");
    endtask
    task automatic results();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        #1000000;
        n_mismatch++;
        results();
    end
    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_read();
        t_write();
        results();
    end
endmodule
